// [rtl/vdb_map.vh]
/*
  Constants for the divider bus slave: bus address, command codes, read-back
  byte layout, reset values and the power-good hold time.
  Assumes a 50 MHz system clock; included by every design file of the block.
*/
`ifndef VDB_MAP_VH
`define VDB_MAP_VH

// bus framing
`define VDB_SLAVE_ADDR 7'h71
`define VDB_RW_READ 1'h1
`define VDB_LAST_BIT 4'h7
`define VDB_BIT_CNT_W 4

// command field, bits 7..5 of the command byte
`define VDB_CMD_HI 7
`define VDB_CMD_LO 5
`define VDB_CMD_ON 3'h0
`define VDB_CMD_SETUP 3'h1
`define VDB_CMD_READ 3'h2
`define VDB_CMD_OFF 3'h3

// write byte sequence after the address
`define VDB_BYTE_CMD 2'h0
`define VDB_BYTE_LO 2'h1
`define VDB_BYTE_HI 2'h2
// address byte slot; its ack step wraps the index to the command byte
`define VDB_BYTE_ADDR 2'h3

// divider code placement in a data byte
`define VDB_CODE_HI 7
`define VDB_CODE_LO 3
`define VDB_CODE_W 5
`define VDB_CODE_RST 5'h1f
`define VDB_PAD_BITS 2'h0

// power-good hold time
`define VDB_PG_HOLD_NS 50000
`define VDB_CLK_NS 20
`define VDB_PG_CNT_W 12

// input synchroniser
`define VDB_SYNC_W 4
// idle levels {enable, select, sda, scl}: no false bus edge after reset
`define VDB_SYNC_RST 4'h3

`endif

// [rtl/vdb_sync.v]
/*
  Three-stage synchroniser for the pin inputs of the divider bus slave.
  Assumes asynchronous pins; the output follows only once stages two and
  three agree, so a single-cycle glitch never reaches the bus logic.
*/
`default_nettype none
`include "vdb_map.vh"

module vdb_sync (
  input wire clk,
  input wire nrst,
  input wire [`VDB_SYNC_W-1:0] pin_in,
  input wire [`VDB_SYNC_W-1:0] rst_val,
  output reg [`VDB_SYNC_W-1:0] level_ff
);

  reg [`VDB_SYNC_W-1:0] stage1_ff;
  reg [`VDB_SYNC_W-1:0] stage2_ff;
  reg [`VDB_SYNC_W-1:0] stage3_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `VDB_SYNC_W; gi = gi + 1)
    begin : g_bit
      // rst_val is a tie-off constant at the instance
      always @(posedge clk)
      begin
        if (!nrst)
        begin
          stage1_ff[gi] <= rst_val[gi];
          stage2_ff[gi] <= rst_val[gi];
          stage3_ff[gi] <= rst_val[gi];
          level_ff[gi] <= rst_val[gi];
        end
        else
        begin
          stage1_ff[gi] <= pin_in[gi];
          stage2_ff[gi] <= stage1_ff[gi];
          stage3_ff[gi] <= stage2_ff[gi];
          if (stage2_ff[gi] == stage3_ff[gi]) // R25
            level_ff[gi] <= stage3_ff[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [rtl/vdb_pg_timer.v]
/*
  Power-good hold timer: a trigger pulse reloads a down counter and busy
  stays high for the hold time. Assumes the 50 MHz system clock; a trigger
  while running restarts the full hold.
*/
`default_nettype none
`include "vdb_map.vh"

module vdb_pg_timer (
  input wire clk,
  input wire nrst,
  input wire trig,
  output wire busy
);

  localparam integer HOLD_INT = `VDB_PG_HOLD_NS / `VDB_CLK_NS;
  localparam [`VDB_PG_CNT_W-1:0] HOLD_CYC = HOLD_INT[`VDB_PG_CNT_W-1:0];
  localparam [`VDB_PG_CNT_W-1:0] ONE = 12'h001;

  reg [`VDB_PG_CNT_W-1:0] cnt_ff;

  always @(posedge clk)
  begin
    if (!nrst)
      cnt_ff <= {`VDB_PG_CNT_W{1'b0}};
    else if (trig)
      cnt_ff <= HOLD_CYC; // R23 R25
    else if (cnt_ff != {`VDB_PG_CNT_W{1'b0}})
      cnt_ff <= cnt_ff - ONE;
  end

  assign busy = (cnt_ff != {`VDB_PG_CNT_W{1'b0}});

endmodule
`default_nettype wire

// [rtl/vdb_top.v]
/*
  Bus slave for a programmable feedback divider: two code slots written by
  a Setup transfer, read back with the converter-off status, a two-step
  on/off sequencer, rail shutdown outputs and a timed power-good pin.
  Assumes scl/sda/select/enable arrive asynchronously and that the bus
  clock is far slower than clk; open-drain pins are resolved outside.
*/
// Behaviour
// [R1] sample sda on scl rise, drive on fall
// [R2] answer only fixed address seven-one hex
// [R3] last address bit gives transfer direction
// [R4] decode command top three bits only
// [R5] codes: on, off, setup, read-back
// [R6] setup bytes load slot 0 then 1
// [R7] host frames write: start, four bytes, stop
// [R8] address mismatch: idle, sda released
// [R9] acknowledge matching address for one clock
// [R10] acknowledge the command byte
// [R11] ack data always, store only for setup
// [R12] idle after final write acknowledge
// [R13] read: repeated start, ack, send slot 0
// [R14] host acks first byte, nacks slot 1
// [R15] read byte: code, off status, zeros
// [R16] select input picks active slot code
// [R17] ignore on until a setup landed
// [R18] two adjacent on commands set bus-on
// [R19] two adjacent off commands clear bus-on
// [R20] slots locked while bus-on and enable
// [R21] off status is nand; rails held low
// [R22] open-drain pins pulled low or released
// [R23] power-good held low after turn-on/select
// [R24] reset: slots ones, off, bus idle
// [R25] synchronise inputs, counted hold timer
`default_nettype none
`include "vdb_map.vh"

module vdb_top (
  input wire clk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire divider_select_in,
  input wire global_enable_in,
  output reg [`VDB_CODE_W-1:0] divider_code,
  output wire [2:0] rail_en_out,
  output wire [2:0] rail_en_oe,
  output wire power_good_out,
  output wire power_good_oe,
  output reg converter_off_status,
  output reg bus_on_state
);

  ////////////////////////////////////////////////////////////////////////////
  // state encoding and helpers

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_WACK = 6'h04;
  localparam [5:0] ST_WBYTE = 6'h08;
  localparam [5:0] ST_RBYTE = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  localparam [`VDB_BIT_CNT_W-1:0] BIT_ONE = 4'h1;
  localparam [1:0] BYTE_ONE = 2'h1;

  function [7:0] read_byte;
    input [`VDB_CODE_W-1:0] code;
    input off_bit;
    begin
      read_byte = {code, off_bit, `VDB_PAD_BITS}; // R15
    end
  endfunction

  function cmd_is;
    input [7:0] cmd;
    input [2:0] code;
    begin
      cmd_is = (cmd[`VDB_CMD_HI:`VDB_CMD_LO] == code); // R4 R5
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection

  wire [`VDB_SYNC_W-1:0] sync_lvl;
  wire scl_s;
  wire sda_s;
  wire sel_s;
  wire en_s;

  vdb_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in({global_enable_in, divider_select_in, sda_in, scl_in}),
    .rst_val(`VDB_SYNC_RST),
    .level_ff(sync_lvl)
  ); // R25

  assign scl_s = sync_lvl[0];
  assign sda_s = sync_lvl[1];
  assign sel_s = sync_lvl[2];
  assign en_s = sync_lvl[3];

  reg scl_d_ff;
  reg sda_d_ff;
  reg sel_d_ff;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      sel_d_ff <= 1'b0;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      sel_d_ff <= sel_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  // both lines pass equal sync depth, so data edges stay inside scl low
  wire bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s; // R7
  wire bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s; // R7

  ////////////////////////////////////////////////////////////////////////////
  // bus protocol engine

  reg [5:0] state_ff;
  reg [`VDB_BIT_CNT_W-1:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] cmd_ff;
  reg [`VDB_CODE_W-1:0] data_lo_ff;
  reg [1:0] byte_idx_ff;
  reg ack_phase_ff;
  reg is_read_ff;
  reg rd_pend_ff;
  reg host_ack_ff;
  reg rd_second_ff;
  reg [`VDB_CODE_W-1:0] slot0_ff;
  reg [`VDB_CODE_W-1:0] slot1_ff;
  reg setup_done_ff;
  reg pend_on_ff;
  reg pend_off_ff;
  reg seq_on_ff;
  reg seq_off_ff;

  wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
  wire locked = bus_on_state & en_s; // R20

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE; // R24
      bit_cnt_ff <= {`VDB_BIT_CNT_W{1'b0}};
      shift_ff <= 8'h00;
      cmd_ff <= 8'h00;
      data_lo_ff <= {`VDB_CODE_W{1'b0}};
      byte_idx_ff <= `VDB_BYTE_CMD;
      ack_phase_ff <= 1'b0;
      is_read_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      host_ack_ff <= 1'b0;
      rd_second_ff <= 1'b0;
      sda_oe <= 1'b0;
      slot0_ff <= `VDB_CODE_RST; // R24
      slot1_ff <= `VDB_CODE_RST; // R24
      setup_done_ff <= 1'b0;
      bus_on_state <= 1'b0;
      pend_on_ff <= 1'b0;
      pend_off_ff <= 1'b0;
      seq_on_ff <= 1'b0;
      seq_off_ff <= 1'b0;
    end
    else if (bus_stop)
    begin
      // a stop ends any transfer; an unfinished read-back is dropped
      state_ff <= ST_IDLE;
      sda_oe <= 1'b0;
      rd_pend_ff <= 1'b0;
    end
    else if (bus_start)
    begin
      // repeated start included: restart address reception
      state_ff <= ST_ADDR;
      bit_cnt_ff <= {`VDB_BIT_CNT_W{1'b0}};
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          sda_oe <= 1'b0;
        end
        ST_ADDR:
        begin
          if (scl_rise) // R1
          begin
            shift_ff <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + BIT_ONE;
            if (bit_cnt_ff == `VDB_LAST_BIT)
            begin
              if (rx_byte[7:1] != `VDB_SLAVE_ADDR) // R2 R8
                state_ff <= ST_IDLE;
              else if (rx_byte[0] == `VDB_RW_READ && !rd_pend_ff) // R3 R13
                state_ff <= ST_IDLE;
              else
              begin
                // any transfer to us breaks a pending on/off pair
                seq_on_ff <= pend_on_ff; // R18
                seq_off_ff <= pend_off_ff; // R19
                pend_on_ff <= 1'b0;
                pend_off_ff <= 1'b0;
                is_read_ff <= rx_byte[0]; // R3
                rd_pend_ff <= 1'b0;
                byte_idx_ff <= `VDB_BYTE_ADDR;
                ack_phase_ff <= 1'b0;
                state_ff <= ST_WACK; // R9
              end
            end
          end
        end
        ST_WACK:
        begin
          if (scl_fall && !ack_phase_ff)
          begin
            sda_oe <= 1'b1; // R9 R10 R11
            ack_phase_ff <= 1'b1;
          end
          else if (scl_fall)
          begin
            ack_phase_ff <= 1'b0;
            bit_cnt_ff <= {`VDB_BIT_CNT_W{1'b0}};
            if (is_read_ff)
            begin
              shift_ff <= read_byte(slot0_ff, converter_off_status); // R13
              sda_oe <= ~read_byte(slot0_ff, converter_off_status) >> 7 == 8'h01;
              rd_second_ff <= 1'b0;
              state_ff <= ST_RBYTE;
            end
            else if (byte_idx_ff == `VDB_BYTE_HI)
            begin
              sda_oe <= 1'b0;
              state_ff <= ST_IDLE; // R12
              if (cmd_is(cmd_ff, `VDB_CMD_SETUP)) // R6 R11
              begin
                if (!locked) // R20
                begin
                  slot0_ff <= data_lo_ff; // R6
                  slot1_ff <= shift_ff[`VDB_CODE_HI:`VDB_CODE_LO]; // R6
                  setup_done_ff <= 1'b1; // R17
                end
              end
              else if (cmd_is(cmd_ff, `VDB_CMD_ON) && setup_done_ff) // R17
              begin
                pend_on_ff <= 1'b1;
                if (seq_on_ff)
                  bus_on_state <= 1'b1; // R18
              end
              else if (cmd_is(cmd_ff, `VDB_CMD_OFF))
              begin
                pend_off_ff <= 1'b1;
                if (seq_off_ff)
                  bus_on_state <= 1'b0; // R19
              end
            end
            else
            begin
              sda_oe <= 1'b0;
              byte_idx_ff <= byte_idx_ff + BYTE_ONE;
              state_ff <= ST_WBYTE;
            end
          end
        end
        ST_WBYTE:
        begin
          if (scl_rise) // R1
          begin
            shift_ff <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + BIT_ONE;
            if (bit_cnt_ff == `VDB_LAST_BIT)
            begin
              if (byte_idx_ff == `VDB_BYTE_CMD)
              begin
                cmd_ff <= rx_byte; // R10
                // read-back needs the repeated start; it owns no data bytes
                rd_pend_ff <= cmd_is(rx_byte, `VDB_CMD_READ); // R13
              end
              else if (byte_idx_ff == `VDB_BYTE_LO)
                data_lo_ff <= rx_byte[`VDB_CODE_HI:`VDB_CODE_LO];
              state_ff <= ST_WACK; // R10 R11
            end
          end
        end
        ST_RBYTE:
        begin
          if (scl_fall) // R1
          begin
            bit_cnt_ff <= bit_cnt_ff + BIT_ONE;
            if (bit_cnt_ff == `VDB_LAST_BIT)
            begin
              sda_oe <= 1'b0;
              host_ack_ff <= 1'b0;
              state_ff <= ST_RACK;
            end
            else
            begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_oe <= ~shift_ff[6]; // R22
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            host_ack_ff <= ~sda_s; // R14
            if (sda_s || rd_second_ff)
              state_ff <= ST_IDLE; // R14
          end
          else if (scl_fall && host_ack_ff)
          begin
            shift_ff <= read_byte(slot1_ff, converter_off_status); // R14
            sda_oe <= ~read_byte(slot1_ff, converter_off_status) >> 7 == 8'h01;
            bit_cnt_ff <= {`VDB_BIT_CNT_W{1'b0}};
            rd_second_ff <= 1'b1;
            state_ff <= ST_RBYTE;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // converter control and power good

  wire off_next = ~(en_s & bus_on_state); // R21
  wire pg_busy;
  // turn-on edge, or a select change while running, restarts the hold
  wire pg_trig = (converter_off_status & ~off_next) |
                 (~converter_off_status & (sel_s ^ sel_d_ff)); // R23

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      converter_off_status <= 1'b1; // R24
      divider_code <= `VDB_CODE_RST;
    end
    else
    begin
      converter_off_status <= off_next; // R21
      divider_code <= sel_s ? slot1_ff : slot0_ff; // R16
    end
  end

  vdb_pg_timer u_pg_timer (
    .clk(clk),
    .nrst(nrst),
    .trig(pg_trig),
    .busy(pg_busy)
  );

  assign rail_en_out = 3'h0;
  assign rail_en_oe = {3{converter_off_status}}; // R21 R22
  assign power_good_out = 1'b0;
  assign power_good_oe = converter_off_status | pg_busy; // R22 R23

endmodule
`default_nettype wire

// [sim/vdb_assertions.sv]
/* pin checker for vdb_top.
   sees only the top ports; power-good hold near 2500 clk */
`default_nettype none
module vdb_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic divider_select_in,
  input wire logic global_enable_in,
  input wire logic [4:0] divider_code,
  input wire logic [2:0] rail_en_out,
  input wire logic [2:0] rail_en_oe,
  input wire logic power_good_out,
  input wire logic power_good_oe,
  input wire logic converter_off_status,
  input wire logic bus_on_state
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] hold_cnt_ff;
  logic [11:0] nxt_hold_cnt;
  // clears while power-good is released or the converter is off, so both triggers measure alike
  assign nxt_hold_cnt = (power_good_oe && !converter_off_status) ?
    hold_cnt_ff + 12'h001 : 12'h000;
  always_ff @(posedge clk)
    hold_cnt_ff <= nrst ? nxt_hold_cnt : 12'h000;
  ////////////////////////////////////////////////////////////////
  property p_rails;
    @(posedge clk) disable iff (!nrst) rail_en_oe == {3{converter_off_status}} &&
      rail_en_out == 3'h0 && power_good_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_rails: assert property (p_rails) else $error("rail pins disagree with off status");
  property p_pg_off;
    @(posedge clk) disable iff (!nrst) converter_off_status |-> power_good_oe;
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("power good released while off");
  property p_rst;
    @(posedge clk) disable iff (!nrst) $rose(nrst) |-> divider_code == 5'h1f &&
      converter_off_status && !bus_on_state && !sda_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("wrong state after reset");
  property p_on;
    @(posedge clk) disable iff (!nrst)
      (bus_on_state && global_enable_in) [*8] |-> !converter_off_status;
  endproperty
  a_on: assert property (p_on) else $error("off status high while enabled and on");
  property p_off_en;
    @(posedge clk) disable iff (!nrst) (!global_enable_in) [*8] |-> converter_off_status;
  endproperty
  a_off_en: assert property (p_off_en) else $error("off status low while disabled");
  property p_hold;
    @(posedge clk) disable iff (!nrst) $fell(power_good_oe) |->
      hold_cnt_ff >= 12'h9ba && hold_cnt_ff <= 12'h9ce;
  endproperty
  a_hold: assert property (p_hold) else $error("power good hold length wrong");
  property p_sda_chg;
    @(posedge clk) disable iff (!nrst) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("sda drive changed with scl high");
  property p_ack;
    @(posedge clk) disable iff (!nrst) $rose(sda_oe) |=> sda_oe [*5];
  endproperty
  a_ack: assert property (p_ack) else $error("sda drive shorter than a bit");
endmodule
`default_nettype wire

// [sim/vdb_host.sv]
/* bus host model for the divider slave.
   scl period 8 clk (low 6, high 2); sda pull-up resolved by the bench */
`default_nettype none
module vdb_host (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // sda moves only with scl low; sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_low = !b;
    repeat (4) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    r = sda_w;
    scl = 1'b0;
  endtask
  task automatic start;
    if (scl == 1'b0)
    begin
      repeat (2) @(negedge clk);
      sda_low = 1'b0;
      repeat (4) @(negedge clk);
      scl = 1'b1;
    end
    repeat (4) @(negedge clk);
    sda_low = 1'b1;
    repeat (4) @(negedge clk);
    scl = 1'b0;
  endtask
  task automatic stop;
    repeat (2) @(negedge clk);
    sda_low = 1'b1;
    repeat (4) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sda_low = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in,
    output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ack_in, ack_out);
  endtask
endmodule
`default_nettype wire

// [sim/vdb_top_test.sv]
/* self-checking bench for vdb_top.
   host model drives the bus; sda is wired-and with a pull-up */
`default_nettype none
module vdb_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, sel, en, scl, host_low, sda_w, sda_out, sda_oe;
  logic [4:0] divider_code;
  logic [2:0] rail_en_out, rail_en_oe;
  logic power_good_out, power_good_oe, converter_off_status, bus_on_state;
  logic [11:0] outs;
  int failures;
  int samples_checked;
  assign sda_w = !(host_low || sda_oe);
  assign outs = {divider_code, converter_off_status, bus_on_state,
    rail_en_oe, power_good_oe, sda_oe};
  vdb_top i_vdb_top (
    .clk, .nrst, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe,
    .divider_select_in(sel), .global_enable_in(en), .divider_code,
    .rail_en_out, .rail_en_oe, .power_good_out, .power_good_oe,
    .converter_off_status, .bus_on_state
  );
  vdb_host i_vdb_host (.clk, .sda_w, .scl, .sda_low(host_low));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, c, lo, hi, input logic [3:0] exp);
    logic [7:0] q;
    logic [3:0] nak;
    i_vdb_host.start();
    i_vdb_host.xfer(a, 1'b1, q, nak[3]);
    i_vdb_host.xfer(c, 1'b1, q, nak[2]);
    i_vdb_host.xfer(lo, 1'b1, q, nak[1]);
    i_vdb_host.xfer(hi, 1'b1, q, nak[0]);
    i_vdb_host.stop();
    chk("write acks", 12'(exp), 12'(nak));
  endtask
  task automatic rd(input logic [7:0] lo_exp, hi_exp);
    logic [7:0] q;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [3:0] nak;
    i_vdb_host.start();
    i_vdb_host.xfer(8'he2, 1'b1, q, nak[3]);
    i_vdb_host.xfer(8'h5a, 1'b1, q, nak[2]);
    i_vdb_host.start();
    i_vdb_host.xfer(8'he3, 1'b1, q, nak[1]);
    i_vdb_host.xfer(8'hff, 1'b0, lo, nak[0]);
    i_vdb_host.xfer(8'hff, 1'b1, hi, q[0]);
    i_vdb_host.stop();
    chk("read acks", 12'h000, 12'(nak));
    chk("slot0 byte", 12'(lo_exp), 12'(lo));
    chk("slot1 byte", 12'(hi_exp), 12'(hi));
  endtask
  task automatic wait_pg(input string what);
    int n;
    n = 0;
    while (power_good_oe !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    while (power_good_oe !== 1'b0 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      failures++;
      test_done();
    end
    else
      chk(what, 12'h001, 12'(n >= 12'h9bf && n <= 12'h9d8));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset;
    chk("reset outs", {5'h1f, 7'h5e}, outs);
    rd(8'hfc, 8'hfc);
  endtask
  task automatic s_early_on;
    wr(8'he2, 8'h00, 8'h50, 8'h98, 4'h0);
    wr(8'he2, 8'h1f, 8'h50, 8'h98, 4'h0);
    chk("bus on early", 12'h000, 12'(bus_on_state));
    wr(8'he4, 8'h20, 8'h50, 8'h98, 4'hf);
    rd(8'hfc, 8'hfc);
  endtask
  task automatic s_setup;
    wr(8'he2, 8'h3f, 8'h50, 8'h98, 4'h0);
    wr(8'he2, 8'h9f, 8'h00, 8'h00, 4'h0);
    wr(8'he2, 8'hff, 8'h00, 8'h00, 4'h0);
    wr(8'he2, 8'h7f, 8'h00, 8'h00, 4'h0);
    rd(8'h54, 8'h9c);
    settle(10);
    chk("code slot0", 12'h00a, 12'(divider_code));
    sel = 1'b1;
    settle(10);
    chk("code slot1", 12'h013, 12'(divider_code));
    sel = 1'b0;
    settle(10);
  endtask
  task automatic s_on_pair;
    wr(8'he2, 8'h00, 8'h00, 8'h00, 4'h0);
    wr(8'he2, 8'h60, 8'h00, 8'h00, 4'h0);
    wr(8'he2, 8'h00, 8'h00, 8'h00, 4'h0);
    chk("on pair broken", 12'h000, 12'(bus_on_state));
    wr(8'he4, 8'h60, 8'h00, 8'h00, 4'hf);
    wr(8'he2, 8'h00, 8'h00, 8'h00, 4'h0);
    chk("on pair", 12'h001, 12'(bus_on_state));
    chk("on not enabled", {5'h0a, 7'h7e}, outs);
    en = 1'b1;
    wait_pg("turn-on hold");
    chk("running outs", {5'h0a, 7'h20}, outs);
  endtask
  task automatic s_lock;
    wr(8'he2, 8'h20, 8'h08, 8'hf8, 4'h0);
    rd(8'h50, 8'h98);
    sel = 1'b1;
    wait_pg("select hold");
    chk("code slot1", 12'h013, 12'(divider_code));
  endtask
  task automatic s_unlock;
    en = 1'b0;
    settle(10);
    chk("disabled outs", {5'h13, 7'h7e}, outs);
    wr(8'he2, 8'h20, 8'h08, 8'hf8, 4'h0);
    rd(8'h0c, 8'hfc);
    en = 1'b1;
    wait_pg("re-enable hold");
    wr(8'he2, 8'h60, 8'h00, 8'h00, 4'h0);
    chk("one off", 12'h001, 12'(bus_on_state));
    wr(8'he2, 8'h60, 8'h00, 8'h00, 4'h0);
    settle(4);
    chk("off pair outs", {5'h1f, 7'h5e}, outs);
  endtask
  initial
  begin
    failures = 0;
    samples_checked = 0;
    nrst = 1'b0;
    sel = 1'b0;
    en = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    settle(6);
    s_reset();
    s_early_on();
    s_setup();
    s_on_pair();
    s_lock();
    s_unlock();
    test_done();
  end
endmodule
bind vdb_top vdb_assertions i_vdb_assertions (
  .clk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe, .divider_select_in,
  .global_enable_in, .divider_code, .rail_en_out, .rail_en_oe, .power_good_out,
  .power_good_oe, .converter_off_status, .bus_on_state
);
`default_nettype wire
